// file: design/cfg_subsys_pkg.sv
/*
  Package for the configuration-header slice that holds the subsystem
  identity words, the option ROM base register and the interrupt routing
  byte. Assumes the configuration cycle decoder and the serial nvRAM engine
  live outside and share one clock with this block.
*/
package cfg_subsys_pkg;

  // byte offsets in configuration space
  localparam logic [7:0] off_subsys_vendor  = 8'h2C;
  localparam logic [7:0] off_subsys         = 8'h2E;
  localparam logic [7:0] off_option_rom     = 8'h30;
  localparam logic [7:0] off_irq_routing    = 8'h3C;

  // dword indices seen on the access port
  localparam logic [5:0] idx_subsys         = off_subsys_vendor[7:2];
  localparam logic [5:0] idx_option_rom     = off_option_rom[7:2];
  localparam logic [5:0] idx_irq_routing    = off_irq_routing[7:2];

  // boot image byte addresses in the nvRAM
  localparam logic [7:0] boot_subsystem_vendor_code_lo       = 8'h6C;
  localparam logic [7:0] boot_subsystem_vendor_code_hi       = 8'h6D;
  localparam logic [7:0] boot_sid_lo        = 8'h6E;
  localparam logic [7:0] boot_sid_hi        = 8'h6F;
  localparam logic [7:0] boot_option_rom    = 8'h70;
  localparam logic [7:0] boot_irq_routing   = 8'h7C;

  // values after reset
  localparam logic [15:0] rst_subsys_id     = 16'h0000;
  localparam logic [20:0] rst_rom_base      = 21'h000000;
  localparam logic [7:0]  rst_irq_routing   = 8'hFF;

  // option ROM window: 2K bytes, decoded on address bits 31:11
  localparam int          rom_window_bits   = 11;
  localparam int          rom_base_bits     = 32 - rom_window_bits;
  localparam logic [1:0]  last_byte_index   = 2'h3;

  typedef enum logic [1:0] {
    st_idle  = 2'b01,
    st_fetch = 2'b10
  } fetch_state_type;

  // one configuration access, dword wide
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  idx;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_type;

  // one byte delivered by the boot loader
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } boot_byte_type;

  // one memory cycle presented for the option ROM window
  typedef struct packed {
    logic        req;
    logic        read;
    logic [31:0] addr;
  } mem_req_type;

endpackage

// file: design/cfg_subsys_regs.sv
/*
  Subsystem identity words, option ROM base register with its 2K window
  and nvRAM-backed read path, and the interrupt routing byte.
  Assumes every input comes from logic on the same PCI clock; the serial
  nvRAM engine answers one byte read at a time with a one-cycle ack.
*/
// Overview of operation
// - Vendor id word at 2Ch is read-only, resets 0, boots from 6Ch-6Dh.
// - An all-zero identity means no subsystem support; shown unchanged.
// - Subsystem word at 2Eh is read-only, resets 0, boots from 6Eh-6Fh.
// - ROM base at 30h: bits 31:11 and 0 writable, 10:1 read 0, resets 0.
// - The ROM register's boot enable comes from nvRAM byte 70h.
// - With the region present, all ones written read back FFFFF801h (2K).
// - With the nvRAM enable clear, configuration reads of 30h return zero.
// - Bit 0 enables ROM decode, only while command memory decode is on.
// - With the nvRAM enable clear, host writes to decode enable are ignored.
// - A ROM window read is filled by four nvRAM byte reads into one dword.
// - Routing byte at 3Ch resets to FFh, boots from 7Ch, host-writable.
module cfg_subsys_regs
  import cfg_subsys_pkg::*;
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        srst,
  // configuration access
  input  wire cfg_subsys_pkg::cfg_req_type cfg_req,
  output logic [31:0]                      cfg_rdata,
  output logic                             cfg_rvalid,
  // boot loader bytes
  input  wire cfg_subsys_pkg::boot_byte_type boot_byte,
  // memory decode bit of pci_command_word
  input  wire logic                        mem_space_en,
  // option ROM memory cycles
  input  wire cfg_subsys_pkg::mem_req_type mem_req,
  output logic                             mem_hit,
  output logic                             mem_busy,
  output logic [31:0]                      mem_rdata,
  output logic                             mem_done,
  // nvRAM byte reads
  output logic                             nv_rd_req,
  output logic [10:0]                      nv_rd_addr,
  input  wire logic                        nv_rd_ack,
  input  wire logic [7:0]                  nv_rd_data
);
  import cfg_subsys_pkg::*;

  typedef struct packed {
    logic [15:0]     subsystem_vendor_code;
    logic [15:0]     subsystem_code;
    logic [20:0]     rom_base;
    logic            rom_dec_en;
    logic            rom_present;
    logic [7:0]      irq_line;
    logic [31:0]     cfg_rdata;
    logic            cfg_rvalid;
    fetch_state_type fsm;
    logic [1:0]      byte_cnt;
    logic [8:0]      word_addr;
    logic [31:0]     rom_word;
    logic            mem_done;
  } state_type;

  state_type s_q;
  state_type s_d;

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rom_reg_view(input state_type s);
    logic [31:0] r;
    r = '0;
    if (s.rom_present) begin
      r = {s.rom_base, 10'h000, s.rom_dec_en};
    end
    return r;
  endfunction

  logic [31:0] rom_wr_val;
  logic        rom_claim;

  // window is fixed at 2K: every base bit is writable, so all ones
  // written come back as FFFFF801h
  assign rom_wr_val = merge_be(rom_reg_view(s_q), cfg_req.wdata,
                               cfg_req.be);
  assign rom_claim  = mem_space_en && s_q.rom_present && s_q.rom_dec_en
                      && (mem_req.addr[31:rom_window_bits]
                          == s_q.rom_base);

  always_comb begin
    s_d = s_q;
    s_d.cfg_rvalid = 1'b0;
    s_d.mem_done = 1'b0;

    // boot image bytes
    if (boot_byte.valid) begin
      case (boot_byte.addr)
        boot_subsystem_vendor_code_lo:     s_d.subsystem_vendor_code[7:0]  = boot_byte.data;
        boot_subsystem_vendor_code_hi:     s_d.subsystem_vendor_code[15:8] = boot_byte.data;
        boot_sid_lo:      s_d.subsystem_code[7:0]   = boot_byte.data;
        boot_sid_hi:      s_d.subsystem_code[15:8]  = boot_byte.data;
        // upper boot bits are hardwired; only the enable is loaded
        boot_option_rom:  s_d.rom_present = boot_byte.data[0];
        boot_irq_routing: s_d.irq_line = boot_byte.data;
        default: ;
      endcase
    end

    // host writes land after boot bytes in the same cycle
    if (cfg_req.wr) begin
      case (cfg_req.idx)
        idx_option_rom: begin
          if (s_q.rom_present) begin
            s_d.rom_base   = rom_wr_val[31:rom_window_bits];
            s_d.rom_dec_en = rom_wr_val[0];
          end
        end
        idx_irq_routing: begin
          if (cfg_req.be[0]) begin
            s_d.irq_line = cfg_req.wdata[7:0];
          end
        end
        default: ;
      endcase
    end

    // identity words go out as loaded, zero included
    if (cfg_req.rd) begin
      s_d.cfg_rvalid = 1'b1;
      case (cfg_req.idx)
        idx_subsys:      s_d.cfg_rdata = {s_q.subsystem_code, s_q.subsystem_vendor_code};
        idx_option_rom:  s_d.cfg_rdata = rom_reg_view(s_q);
        idx_irq_routing: s_d.cfg_rdata = {24'h000000, s_q.irq_line};
        default:         s_d.cfg_rdata = 32'h00000000;
      endcase
    end

    // option ROM fetch: four byte reads, lowest address first
    case (s_q.fsm)
      st_idle: begin
        // writes to the window are not claimed and so never start a fetch
        if (mem_req.req && mem_req.read && rom_claim) begin
          s_d.fsm = st_fetch;
          s_d.byte_cnt = 2'h0;
          s_d.word_addr = mem_req.addr[rom_window_bits-1:2];
        end
      end
      st_fetch: begin
        if (nv_rd_ack) begin
          s_d.rom_word[8*s_q.byte_cnt +: 8] = nv_rd_data;
          s_d.byte_cnt = s_q.byte_cnt + 2'h1;
          if (s_q.byte_cnt == last_byte_index) begin
            s_d.fsm = st_idle;
            s_d.mem_done = 1'b1;
          end
        end
      end
      default: s_d.fsm = st_idle;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '{subsystem_vendor_code: rst_subsys_id, subsystem_code: rst_subsys_id,
               rom_base: rst_rom_base, rom_dec_en: 1'b0,
               rom_present: 1'b0, irq_line: rst_irq_routing,
               cfg_rdata: 32'h00000000, cfg_rvalid: 1'b0,
               fsm: st_idle, byte_cnt: 2'h0, word_addr: 9'h000,
               rom_word: 32'h00000000, mem_done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata  = s_q.cfg_rdata;
  assign cfg_rvalid = s_q.cfg_rvalid;
  assign mem_hit    = rom_claim && mem_req.req && mem_req.read;
  assign mem_busy   = (s_q.fsm == st_fetch);
  assign mem_rdata  = s_q.rom_word;
  assign mem_done   = s_q.mem_done;
  assign nv_rd_req  = (s_q.fsm == st_fetch);
  assign nv_rd_addr = {s_q.word_addr, s_q.byte_cnt};

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence last_byte_taken;
    nv_rd_req && nv_rd_ack && s_q.byte_cnt == last_byte_index;
  endsequence

  sequence fetch_started;
    s_q.fsm == st_idle && mem_hit;
  endsequence

  a_subsys_read: assert property (
    cfg_req.rd && cfg_req.idx == idx_subsys
    |=> cfg_rdata == {$past(s_q.subsystem_code), $past(s_q.subsystem_vendor_code)} && cfg_rvalid)
    else $error("identity read mismatch");

  a_rom_absent_zero: assert property (
    cfg_req.rd && cfg_req.idx == idx_option_rom && !s_q.rom_present
    |=> cfg_rdata == 32'h00000000)
    else $error("absent rom register not zero");

  a_rom_reserved_zero: assert property (
    cfg_req.rd && cfg_req.idx == idx_option_rom |=> cfg_rdata[10:1] == 10'h000)
    else $error("rom reserved bits nonzero");

  a_decode_locked: assert property (
    !s_q.rom_present && !boot_byte.valid |=> $stable(s_q.rom_dec_en))
    else $error("decode enable moved while locked");

  a_claim_gated: assert property (
    mem_hit |-> mem_space_en && s_q.rom_dec_en
              && mem_req.addr[31:11] == s_q.rom_base)
    else $error("claim without enable or match");

  a_boot_enable: assert property (
    boot_byte.valid && boot_byte.addr == boot_option_rom
    |=> s_q.rom_present == $past(boot_byte.data[0]))
    else $error("boot enable not loaded");

  a_irq_write: assert property (
    cfg_req.wr && cfg_req.idx == idx_irq_routing && cfg_req.be[0]
    |=> s_q.irq_line == $past(cfg_req.wdata[7:0]))
    else $error("routing byte not written");

  a_fetch_first_addr: assert property (
    fetch_started
    |=> nv_rd_req && nv_rd_addr == {$past(mem_req.addr[10:2]), 2'h0})
    else $error("fetch did not start at byte 0");

  a_fetch_done: assert property (
    last_byte_taken |=> mem_done && !nv_rd_req
                        && mem_rdata[31:24] == $past(nv_rd_data))
    else $error("dword not completed after fourth byte");

endmodule

// file: tb/nv_model.sv
/*
  Serial nvRAM byte reader model answering option ROM fetches.
  Assumes the design holds rd_req and rd_addr until it sees ack.
*/
module nv_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // byte read handshake
  input  wire logic        rd_req,
  input  wire logic [10:0] rd_addr,
  input  wire logic [3:0]  slow,
  output logic             ack,
  output logic [7:0]       data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  always @(posedge clock) begin
    if (srst) begin
      ack <= 1'b0;
      wait_q <= 4'h0;
      data <= 8'hA5;
    end else if (!ack && rd_req && wait_q >= slow) begin
      ack <= 1'b1;
      wait_q <= 4'h0;
      data <= {rd_addr[2:0], rd_addr[7:3]} ^ {5'h00, rd_addr[10:8]};
    end else begin
      // toggling so a late sample cannot pass by luck
      ack <= 1'b0;
      data <= ~data;
      wait_q <= rd_req ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

// file: tb/tb.sv
/*
  Self-checking bench for the subsystem id, option ROM and irq byte.
  Assumes the nvRAM model answers byte reads with a one-cycle ack.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cfg_subsys_pkg::*;
  logic          clock = 1'b0;
  logic          srst = 1'b1;
  logic          mem_space_en = 1'b0;
  cfg_req_type   cfg_req = '0;
  boot_byte_type boot_byte = '0;
  mem_req_type   mem_req = '0;
  logic [31:0]   cfg_rdata;
  logic [31:0]   mem_rdata;
  logic          cfg_rvalid;
  logic          mem_hit;
  logic          mem_busy;
  logic          mem_done;
  logic          nv_rd_req;
  logic          nv_rd_ack;
  logic [10:0]   nv_rd_addr;
  logic [7:0]    nv_rd_data;
  logic [3:0]    slow = 4'h0;
  logic [31:0]   base;
  logic [31:0]   a;
  logic [31:0]   v;
  int            err_count = 0;
  int            samples_checked = 0;

  always #20 clock = ~clock;

  cfg_subsys_regs dut_u (.clock(clock), .srst(srst), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .boot_byte(boot_byte),
    .mem_space_en(mem_space_en), .mem_req(mem_req), .mem_hit(mem_hit),
    .mem_busy(mem_busy), .mem_rdata(mem_rdata), .mem_done(mem_done),
    .nv_rd_req(nv_rd_req), .nv_rd_addr(nv_rd_addr),
    .nv_rd_ack(nv_rd_ack), .nv_rd_data(nv_rd_data));
  nv_model nv_u (.clock(clock), .srst(srst), .rd_req(nv_rd_req),
    .rd_addr(nv_rd_addr), .slow(slow), .ack(nv_rd_ack), .data(nv_rd_data));

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask

  // read and optional write in one access; the read sees the old value
  task automatic cfg(logic wr, logic [5:0] idx, logic [31:0] wd,
                     logic [31:0] exp);
    @(negedge clock);
    cfg_req = '{rd: 1'b1, wr: wr, idx: idx, be: 4'hF, wdata: wd};
    @(negedge clock);
    // rvalid stands for the one cycle after the taking edge only
    chk("rvalid", {31'h0, cfg_rvalid}, 32'h1);
    chk("rdata", cfg_rdata, exp);
    cfg_req = '0;
  endtask

  task automatic boot(logic [7:0] ad, logic [7:0] d);
    @(negedge clock);
    boot_byte = '{valid: 1'b1, addr: ad, data: d};
    @(negedge clock);
    boot_byte = '0;
  endtask

  task automatic fetch(logic rd, logic [31:0] ad, logic hit);
    int n;
    int b;
    int e;
    @(negedge clock);
    mem_req = '{req: 1'b1, read: rd, addr: ad};
    #1;
    chk("hit", {31'h0, mem_hit}, {31'h0, hit});
    @(negedge clock);
    mem_req = '0;
    chk("busy", {31'h0, mem_busy}, {31'h0, hit});
    if (hit) begin
      n = 0;
      while (mem_done !== 1'b1 && n < 200) begin
        @(negedge clock);
        n++;
      end
      chk("done", {31'h0, mem_done}, 32'h1);
      e = 0;
      for (int i = 0; i < 4; i++) begin
        b = (int'(ad[10:0]) & 'h7FC) | i;
        e |= (((b & 7) << 5 | (b >> 3) & 31) ^ (b >> 8)) << (8 * i);
      end
      chk("rom", mem_rdata, e);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    conclude;
  end

  initial begin
    void'($urandom(20));
    repeat (16) @(negedge clock);
    srst = 1'b0;
    cfg(0, idx_subsys, 0, 0);
    cfg(0, idx_irq_routing, 0, 32'hFF);
    cfg(1, idx_option_rom, '1, 0);
    cfg(0, idx_option_rom, 0, 0);
    cfg(0, 6'h0D, 0, 0);
    mem_space_en = 1'b1;
    fetch(1, 0, 0);
    for (int p = 0; p < 2; p++) begin
      v = p ? $urandom : 0;
      boot(boot_subsystem_vendor_code_lo, v[7:0]);
      boot(boot_subsystem_vendor_code_hi, v[15:8]);
      boot(boot_sid_lo, v[23:16]);
      boot(boot_sid_hi, v[31:24]);
      cfg(1, idx_subsys, ~v, v);
      cfg(0, idx_subsys, 0, v);
    end
    boot(boot_option_rom, 8'h01);
    cfg(1, idx_option_rom, '1, 0);
    cfg(1, idx_option_rom, 32'hFFFFF800, 32'hFFFFF801);
    cfg(0, idx_option_rom, 0, 32'hFFFFF800);
    fetch(1, 32'hFFFFF800, 0);
    base = $urandom & 32'hFFFFF800;
    cfg(1, idx_option_rom, base | 32'h1, 32'hFFFFF800);
    repeat (4) begin
      a = base | ($urandom & 32'h7FF);
      slow = 4'($urandom % 3);
      fetch(1, a, 1);
    end
    fetch(0, a, 0);
    fetch(1, a ^ 32'h800, 0);
    mem_space_en = 1'b0;
    fetch(1, a, 0);
    v = $urandom;
    boot(boot_irq_routing, v[7:0]);
    cfg(1, idx_irq_routing, v >> 8, {24'h0, v[7:0]});
    cfg(0, idx_irq_routing, 0, {24'h0, v[15:8]});
    conclude;
  end
endmodule
